//--- verilog/cc_timer.sv
// Capture/compare/PWM timer core, standard or wide variant
`timescale 1ns/100ps
// What this block does
// RQ1 - The standard variant has a 16-bit counter with up to four capture/compare channels.
// RQ2 - The wide variant is identical but with a 32-bit counter and 32-bit channel values.
// RQ3 - Each channel runs in exactly one of off, capture, compare or PWM mode at a time.
// RQ4 - In capture mode a selected input event copies the counter into the channel's capture buffer.
// RQ5 - In compare mode the channel output reflects the counter against the programmed threshold.
// RQ6 - In PWM mode the output follows the compare values that software writes in a cycle where the counter wraps; writes at other times are dropped.
// RQ7 - Dead-time insertion exists only in the first unit of each variant.
// RQ8 - The counter can count external events as well as elapsed clock cycles.
// RQ9 - The timer emits triggers to the peripheral event router for other peripherals.
// RQ10 - While enabled the counter steps by one, wraps to zero after its top and flags overflow.
// RQ11 - Each channel sets a flag on capture or match, cleared by a software write.
module cc_timer #(
    parameter bit WIDE     = 1'b0,
    parameter int UNIT_IDX = 0
) (
    // Clock and reset
    input  wire logic                                         clk,
    input  wire logic                                         rst_n,
    // Counter control
    input  wire logic                                         cnt_enable,
    input  wire cc_timer_pkg::cnt_src_e                       cnt_src,
    input  wire logic                                         ext_count_pin,
    input  wire logic [(WIDE ? 32 : 16)-1:0]                  top_value,
    input  wire logic                                         ovf_clr,
    // Channel configuration and compare values
    input  wire cc_timer_pkg::ch_cfg_s [cc_timer_pkg::NUM_CH-1:0] ch_cfg,
    input  wire logic [cc_timer_pkg::NUM_CH-1:0][(WIDE ? 32 : 16)-1:0] cmp_value,
    input  wire logic [cc_timer_pkg::NUM_CH-1:0]              cmp_write,
    input  wire logic [cc_timer_pkg::NUM_CH-1:0]              cap_pin,
    input  wire logic                                         dt_enable,
    input  wire logic [cc_timer_pkg::DT_WIDTH-1:0]            dt_cycles,
    // Results
    output logic [(WIDE ? 32 : 16)-1:0]                       count,
    output logic [cc_timer_pkg::NUM_CH-1:0][(WIDE ? 32 : 16)-1:0] cap_value,
    output logic [cc_timer_pkg::NUM_CH-1:0]                   ch_flag,
    output logic                                              ovf_flag,
    output logic [cc_timer_pkg::NUM_CH-1:0]                   ch_out,
    output logic [cc_timer_pkg::NUM_CH-1:0]                   ch_out_n,
    output cc_timer_pkg::trig_s                               router_trig
);
    localparam int W = WIDE ? cc_timer_pkg::WIDE_WIDTH : cc_timer_pkg::STD_WIDTH; // RQ1 RQ2
    localparam bit HAS_DT = (UNIT_IDX == cc_timer_pkg::FIRST_UNIT_IDX);

    logic [W-1:0]                               cnt_q;
    logic [W-1:0]                               cnt_d;
    logic                                       step;
    logic                                       wrap;
    logic [1:0]                                 ext_sync_q;
    logic                                       ext_prev_q;
    logic [cc_timer_pkg::NUM_CH-1:0][1:0]       cap_sync_q;
    logic [cc_timer_pkg::NUM_CH-1:0]            cap_prev_q;
    logic [cc_timer_pkg::NUM_CH-1:0]            cap_evt;
    logic [cc_timer_pkg::NUM_CH-1:0]            match;
    logic [cc_timer_pkg::NUM_CH-1:0][W-1:0]     cmp_q;
    logic [cc_timer_pkg::NUM_CH-1:0][W-1:0]     cap_q;
    logic [cc_timer_pkg::NUM_CH-1:0]            flag_q;
    logic                                       ovf_q;
    logic [cc_timer_pkg::NUM_CH-1:0]            raw_q;
    logic [cc_timer_pkg::NUM_CH-1:0]            out_q;
    logic [cc_timer_pkg::NUM_CH-1:0]            out_n_q;
    logic [cc_timer_pkg::NUM_CH-1:0][cc_timer_pkg::DT_WIDTH-1:0] dt_q;
    cc_timer_pkg::trig_s                        trig_q;

    // Edge select decode, shared by all channels
    function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic was);
        edge_hit = (sel[0] & now & ~was) | (sel[1] & ~now & was);
    endfunction

    // Pin synchronisers; only the second stage feeds logic
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ext_sync_q <= 2'h0;
            ext_prev_q <= 1'h0;
            cap_sync_q <= '0;
            cap_prev_q <= '0;
        end else begin
            ext_sync_q <= {ext_sync_q[0], ext_count_pin};
            ext_prev_q <= ext_sync_q[1];
            for (int i = 0; i < cc_timer_pkg::NUM_CH; i++) begin
                cap_sync_q[i] <= {cap_sync_q[i][0], cap_pin[i]};
                cap_prev_q[i] <= cap_sync_q[i][1];
            end
        end
    end

    // Counting source: every clock or each rising external edge
    assign step = cnt_enable & ((cnt_src == cc_timer_pkg::SRC_CLOCK) |
                                (ext_sync_q[1] & ~ext_prev_q)); // RQ8
    assign wrap = step & (cnt_q == top_value);
    assign cnt_d = wrap ? '0 : (step ? W'(cnt_q + W'(1)) : cnt_q); // RQ10

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Overflow flag; a new wrap beats a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ovf_q <= 1'h0;
        end else if (wrap) begin
            ovf_q <= 1'h1; // RQ10
        end else if (ovf_clr) begin
            ovf_q <= 1'h0;
        end
    end

    // Event and match detection per channel; mode is a single enum so only one applies
    always_comb begin
        for (int i = 0; i < cc_timer_pkg::NUM_CH; i++) begin
            cap_evt[i] = (ch_cfg[i].mode == cc_timer_pkg::MODE_CAPTURE) &
                         edge_hit(ch_cfg[i].cap_edge, cap_sync_q[i][1], cap_prev_q[i]); // RQ3
            match[i]   = ((ch_cfg[i].mode == cc_timer_pkg::MODE_COMPARE) |
                          (ch_cfg[i].mode == cc_timer_pkg::MODE_PWM)) & step & (cnt_q == cmp_q[i]);
        end
    end

    // Compare values; PWM takes new values only at wrap so each period is glitch free
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmp_q <= '0;
        end else begin
            for (int i = 0; i < cc_timer_pkg::NUM_CH; i++) begin
                if (cmp_write[i] && (ch_cfg[i].mode != cc_timer_pkg::MODE_PWM || wrap)) begin
                    cmp_q[i] <= cmp_value[i]; // RQ6
                end
            end
        end
    end

    // Capture buffers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cap_q <= '0;
        end else begin
            for (int i = 0; i < cc_timer_pkg::NUM_CH; i++) begin
                if (cap_evt[i]) begin
                    cap_q[i] <= cnt_q; // RQ4
                end
            end
        end
    end

    // Channel flags, set wins over clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flag_q <= '0;
        end else begin
            for (int i = 0; i < cc_timer_pkg::NUM_CH; i++) begin
                if (cap_evt[i] || match[i]) begin
                    flag_q[i] <= 1'h1; // RQ11
                end else if (ch_cfg[i].flag_clr) begin
                    flag_q[i] <= 1'h0; // RQ11
                end
            end
        end
    end

    // Raw channel waveform before dead time
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            raw_q <= '0;
        end else begin
            for (int i = 0; i < cc_timer_pkg::NUM_CH; i++) begin
                unique case (ch_cfg[i].mode)
                    cc_timer_pkg::MODE_COMPARE: raw_q[i] <= (cnt_d >= cmp_q[i]); // RQ5
                    cc_timer_pkg::MODE_PWM:     raw_q[i] <= (cnt_d < cmp_q[i]);  // RQ6
                    cc_timer_pkg::MODE_CAPTURE: raw_q[i] <= 1'h0;
                    cc_timer_pkg::MODE_OFF:     raw_q[i] <= 1'h0;
                endcase
            end
        end
    end

    // Dead time: delay each rising edge of either output; absent in later units
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dt_q    <= '0;
            out_q   <= '0;
            out_n_q <= '0;
        end else begin
            for (int i = 0; i < cc_timer_pkg::NUM_CH; i++) begin
                if (HAS_DT && dt_enable && ch_cfg[i].mode == cc_timer_pkg::MODE_PWM) begin // RQ7
                    if (raw_q[i] != out_q[i] || raw_q[i] == out_n_q[i]) begin
                        if (out_q[i] || out_n_q[i]) begin
                            out_q[i]   <= 1'h0;
                            out_n_q[i] <= 1'h0;
                            dt_q[i]    <= dt_cycles;
                        end else if (dt_q[i] != '0) begin
                            dt_q[i] <= dt_q[i] - 1'h1;
                        end else begin
                            out_q[i]   <= raw_q[i];
                            out_n_q[i] <= ~raw_q[i];
                        end
                    end
                end else begin
                    out_q[i]   <= raw_q[i];
                    out_n_q[i] <= (ch_cfg[i].mode == cc_timer_pkg::MODE_PWM) & ~raw_q[i];
                    dt_q[i]    <= '0;
                end
            end
        end
    end

    // Router triggers, one-cycle pulses
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trig_q <= '0;
        end else begin
            trig_q.overflow <= wrap;           // RQ9
            trig_q.ch_event <= cap_evt | match; // RQ9
        end
    end

    assign count       = cnt_q;
    assign cap_value   = cap_q;
    assign ch_flag     = flag_q;
    assign ovf_flag    = ovf_q;
    assign ch_out      = out_q;
    assign ch_out_n    = out_n_q;
    assign router_trig = trig_q;
endmodule

//--- verilog/cc_timer_pkg.sv
// Shared constants and carriers for the capture/compare/PWM timer
package cc_timer_pkg;
    localparam int NUM_CH         = 4;
    localparam int STD_WIDTH      = 16;
    localparam int WIDE_WIDTH     = 32;
    localparam int DT_WIDTH       = 8;
    localparam int DT_RESET       = 0;
    localparam int FIRST_UNIT_IDX = 0;

    // Channel mode encoding
    typedef enum logic [1:0] {
        MODE_OFF     = 2'h0,
        MODE_CAPTURE = 2'h1,
        MODE_COMPARE = 2'h2,
        MODE_PWM     = 2'h3
    } ch_mode_e;

    // Counter clock source
    typedef enum logic [0:0] {
        SRC_CLOCK = 1'h0,
        SRC_EVENT = 1'h1
    } cnt_src_e;

    // Per-channel configuration
    typedef struct packed {
        ch_mode_e   mode;
        logic [1:0] cap_edge;
        logic       flag_clr;
    } ch_cfg_s;

    // Events toward the router
    typedef struct packed {
        logic                overflow;
        logic [NUM_CH-1:0]   ch_event;
    } trig_s;
endpackage

//--- verif/cc_timer_asserts.sv
`timescale 1ns/100ps
// Port checker for the timer
module cc_timer_asserts #(parameter bit WIDE = 1'b0) (
    // Watched ports
    input wire logic                        clk, rst_n, cnt_enable, ovf_clr, dt_enable, ovf_flag,
    input wire cc_timer_pkg::cnt_src_e      cnt_src,
    input wire logic [(WIDE ? 32 : 16)-1:0] top_value, count,
    input wire cc_timer_pkg::ch_cfg_s [3:0] ch_cfg,
    input wire logic [3:0]                  ch_flag, ch_out, ch_out_n,
    input wire cc_timer_pkg::trig_s         router_trig
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // A counting step on the clock source
    logic tick;
    assign tick = cnt_enable && cnt_src == cc_timer_pkg::SRC_CLOCK;
    property p_step; tick && count < top_value |=> count == $past(count) + 1'b1; endproperty
    a_step: assert property (p_step) else $error("count did not step");
    property p_wrap; tick && count == top_value |=> count == '0; endproperty
    a_wrap: assert property (p_wrap) else $error("count did not wrap");
    property p_hold; !cnt_enable |=> $stable(count); endproperty
    a_hold: assert property (p_hold) else $error("count moved while stopped");
    property p_ovf_set; tick && count == top_value |-> ##[1:2] ovf_flag; endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow not flagged");
    property p_ovf_keep; ovf_flag && !ovf_clr |=> ovf_flag; endproperty
    a_ovf_keep: assert property (p_ovf_keep) else $error("overflow flag lost");
    // Counter stopped two edges, so no wrap can still be pending
    property p_ovf_clr; ovf_clr && !cnt_enable && !$past(cnt_enable) |=> !ovf_flag; endproperty
    a_ovf_clr: assert property (p_ovf_clr) else $error("overflow flag not cleared");
    // A top of zero wraps every cycle, so back-to-back pulses are legal there
    property p_trig; router_trig.overflow && top_value != '0 |=> !router_trig.overflow; endproperty
    a_trig: assert property (p_trig) else $error("trigger longer than a cycle");
    // A channel trigger always comes with its flag, set wins over clear
    property p_ch_trig; router_trig.ch_event != '0 |-> (router_trig.ch_event & ~ch_flag) == '0; endproperty
    a_ch_trig: assert property (p_ch_trig) else $error("channel trigger without flag");
    property p_pwm_n;
        (ch_cfg[0].mode == cc_timer_pkg::MODE_PWM && !dt_enable)[*3] |-> ch_out_n[0] == !ch_out[0];
    endproperty
    a_pwm_n: assert property (p_pwm_n) else $error("pwm pair not complementary");
    c_wrap: cover property (tick && count == top_value);
    c_capture: cover property ($rose(ch_flag[1]));
    c_pwm: cover property (ch_out[0] && ch_cfg[0].mode == cc_timer_pkg::MODE_PWM);
endmodule
bind cc_timer cc_timer_asserts #(.WIDE(WIDE)) u_asserts (.clk, .rst_n, .cnt_enable, .ovf_clr, .dt_enable,
    .ovf_flag, .cnt_src, .top_value, .count, .ch_cfg, .ch_flag, .ch_out, .ch_out_n, .router_trig);

//--- verif/pin_model.sv
`timescale 1ns/100ps
// Pin-side partner: slow pin pulses on request, tally of overflow triggers
module pin_model (
    // Clock, requests, triggers, pins and tally
    input  wire logic                clk,
    input  wire logic [4:0]          pulse_req,
    input  wire cc_timer_pkg::trig_s trig,
    output logic [4:0]               pins,
    output int                       ovf_seen
);
    logic [2:0] age    = 3'h0;
    logic [4:0] pins_q = 5'h00;
    int         seen_q = 0;
    // Pins held five cycles so the synchroniser cannot miss an edge; idle low
    always @(posedge clk) begin
        age    <= (pulse_req != 5'h00) ? 3'h5 : age - {2'h0, age != 3'h0};
        pins_q <= (pulse_req != 5'h00) ? pulse_req : (age > 3'h1 ? pins_q : 5'h00);
        seen_q <= seen_q + trig.overflow;
    end
    // One driver per output
    assign pins     = pins_q;
    assign ovf_seen = seen_q;
endmodule

//--- verif/capture_compare_pwm_timer_bench.sv
`timescale 1ns/100ps
// Self-checking bench for the capture/compare/PWM timer
module capture_compare_pwm_timer_bench;
    logic clk, rst_n, cnt_enable, ovf_clr, dt_enable, ovf_flag;
    logic [15:0] top_value, count;
    logic [3:0] cmp_write, ch_flag, ch_out, ch_out_n;
    logic [4:0] req, pins;
    logic [7:0] dt_cycles;
    logic [3:0][15:0] cmp_value, cap_value;
    cc_timer_pkg::cnt_src_e cnt_src;
    cc_timer_pkg::ch_cfg_s [3:0] ch_cfg;
    cc_timer_pkg::trig_s trig;
    int errors = 0, check_count = 0, ovf_seen, hi, lo, both;
    // First unit, the one with dead time
    cc_timer #(.WIDE(1'b0), .UNIT_IDX(0)) u_dut (.clk, .rst_n, .cnt_enable, .cnt_src, .ext_count_pin(pins[4]),
        .top_value, .ovf_clr, .ch_cfg, .cmp_value, .cmp_write, .cap_pin(pins[3:0]), .dt_enable, .dt_cycles,
        .count, .cap_value, .ch_flag, .ovf_flag, .ch_out, .ch_out_n, .router_trig(trig));
    pin_model u_pins (.clk, .pulse_req(req), .trig, .pins, .ovf_seen);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Wrap at a small top, then count pin edges only
    task automatic t_count();
        top_value = 16'h0003;
        cnt_enable = 1'b1;
        for (int i = 1; i <= 4; i++) begin
            step(1);
            check(count, i % 4);
        end
        cnt_enable = 1'b0;
        step(2);
        check({ovf_flag, 16'(ovf_seen)}, 32'h0001_0001);
        ovf_clr = 1'b1;
        cnt_src = cc_timer_pkg::SRC_EVENT;
        step(1);
        {ovf_clr, cnt_enable} = 2'b01;
        repeat (3) begin
            req = 5'h10;
            step(1);
            req = 5'h00;
            step(9);
        end
        check({ovf_flag, count}, 32'h3);
        cnt_src = cc_timer_pkg::SRC_CLOCK;
        cnt_enable = 1'b0;
    endtask
    // Capture on ch1 while ch2 ignores its pin, then compare on ch2 and ch3
    task automatic t_chan();
        ch_cfg[1] = '{cc_timer_pkg::MODE_CAPTURE, 2'h1, 1'b0};
        ch_cfg[2].mode = cc_timer_pkg::MODE_COMPARE;
        ch_cfg[3].mode = cc_timer_pkg::MODE_COMPARE;
        cmp_value[3:2] = {16'h0008, 16'h0005};
        {req, cmp_write} = {5'h06, 4'hC};
        step(1);
        {req, cmp_write} = '0;
        step(9);
        check({ch_flag, cap_value[1], cap_value[2][11:0]}, {4'h2, 16'h0003, 12'h000});
        {ch_cfg[1].flag_clr, cnt_enable} = 2'b11;
        top_value = 16'h0009;
        step(3);
        {ch_cfg[1].flag_clr, cnt_enable} = 2'b00;
        step(2);
        check({count, ch_flag, ch_out[3:2]}, {16'h0006, 4'h4, 2'h1});
    endtask
    // Duty follows each threshold; dead time keeps the pair apart
    task automatic t_pwm();
        ch_cfg[0].mode = cc_timer_pkg::MODE_PWM;
        cnt_enable = 1'b1;
        for (int k = 2; k <= 8; k += 3) begin
            {dt_enable, cmp_value[0], cmp_write[0]} = {k == 5, 16'(k), 1'b1};
            step(12);
            cmp_write[0] = 1'b0;
            step(10);
            {hi, lo, both} = '0;
            repeat (10) begin
                step(1);
                hi += ch_out[0];
                lo += ch_out_n[0];
                both += ch_out[0] & ch_out_n[0];
            end
            check(both, 0);
            if (!dt_enable) check({hi[7:0], lo[7:0]}, {8'(k), 8'(10 - k)});
            else check({hi > 0, lo > 0, hi < k, lo < 10 - k}, 4'hF);
        end
    endtask
    initial begin
        {rst_n, cnt_enable, ovf_clr, dt_enable, cmp_write, req, ch_cfg, cmp_value} = '0;
        cnt_src = cc_timer_pkg::SRC_CLOCK;
        {top_value, dt_cycles} = {16'hFFFF, 8'h02};
        step(3);
        rst_n = 1'b1;
        check({count, ch_flag, ch_out, ovf_flag, trig}, 32'h0);
        t_count();
        t_chan();
        t_pwm();
        test_done();
    end
    // Watchdog far beyond the roughly 150 cycles needed
    initial begin
        #100000;
        errors++;
        test_done();
    end
endmodule
